// *** hdl/frx_regs.svh ***
`ifndef FRX_REGS_SVH
`define FRX_REGS_SVH

// =====================================================================
// Field positions of the exception vectors (cause, flag, enable).
`define FRX_EXC_I 0
`define FRX_EXC_U 1
`define FRX_EXC_O 2
`define FRX_EXC_Z 3
`define FRX_EXC_V 4
`define FRX_EXC_E 5

// =====================================================================
// Rounding selections.
`define FRX_RND_NEAREST 2'h0
`define FRX_RND_ZERO 2'h1

// =====================================================================
// Reset values.
`define FRX_XFER_RESET 32'h00000000
`define FRX_FREG_RESET 32'h00000000

// =====================================================================
// Default results, single and double precision.
`define FRX_QNAN_S 32'h7FBFFFFF
`define FRX_QNAN_D 64'h7FF7FFFFFFFFFFFF
`define FRX_INF_S 31'h7F800000
`define FRX_INF_D 63'h7FF0000000000000
`define FRX_MAX_S 31'h7F7FFFFF
`define FRX_MAX_D 63'h7FEFFFFFFFFFFFFF

`endif

// *** hdl/frx_pkg.sv ***
package frx_pkg;

    typedef enum logic [1:0]
    {
        FRX_ST_IDLE = 2'h0,
        FRX_ST_EXEC = 2'h1,
        FRX_ST_WB = 2'h3,
        FRX_ST_TRAP = 2'h2
    } frx_state_t;

    typedef enum logic [2:0]
    {
        FRX_OP_NONE = 3'h0,
        FRX_OP_ARITH = 3'h1,
        FRX_OP_DIV = 3'h2,
        FRX_OP_RSQRT = 3'h3,
        FRX_OP_XFORM = 3'h4,
        FRX_OP_INNER = 3'h5,
        FRX_OP_MOVE = 3'h6
    } frx_op_t;

    typedef enum logic [1:0]
    {
        FRX_DIS_NONE = 2'h0,
        FRX_DIS_GENERAL = 2'h1,
        FRX_DIS_SLOT = 2'h2
    } frx_disable_t;

endpackage

// *** hdl/frx_regbank.sv ***
`timescale 1ns/10ps
`include "frx_regs.svh"

// Summary of operation
// - Thirty-two physical 32-bit registers in bank 0 and bank 1.
// - Single views use bank 0 when bank select is 0, else bank 1.
// - Alternate single views use the bank not chosen for single views.
// - Eight double views pair single views, even index high word.
// - Four vector views group single views from index 0, 4, 8, 12.
// - Eight alternate double views pair alternate single views.
// - All sixteen alternate single views form one 4x4 matrix.
// - Transfer word carries all CPU data; load writes, store reads.
// - Rounding happens once, on the final result only.
// - Rounding select 00 is nearest, 01 is toward zero.
// - Nearest mode breaks ties toward an even least bit.
// - Nearest mode gives signed infinity at or above the overflow bound.
// - Toward-zero truncates and saturates at largest magnitude with sign.
// - Any issued instruction with unit disable set raises slot or general disable, moves included; transfer word loads and stores raise none.
// - Six sources detected; inexact also on overflow or underflow.
// - Six cause bits, flags and enables only for five; error unmaskable.
// - Causes rewritten every instruction; flags are sticky on occurrence.
// - Denormal input with flush off always traps.
// - Invalid enable traps on transforms and invalids; divide enable on zero.
// - Overflow, underflow, inexact enables trap on any possible producer.
// - One common exception event; destination unchanged when trapping.
// - Untrapped invalid gives quiet NaN; divide by zero gives signed infinity.
// - Untrapped overflow gives signed max in zero mode, infinity in nearest.
// - Untrapped underflow gives signed denormal or zero, zero when flushing.
module frx_regbank
    import frx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic issue,
    input wire frx_op_t op_kind,
    input wire logic in_delay_slot,
    input wire logic unit_disable_bit,
    input wire logic bank_select_bit,
    input wire logic [1:0] rounding_select,
    input wire logic denormal_flush,
    input wire logic [4:0] enable_bits,
    input wire logic [5:0] flag_clear,
    input wire logic is_double,
    input wire logic [4:0] src_reg,
    input wire logic [3:0] dst_reg,
    input wire logic src_denormal,
    input wire logic src_invalid,
    input wire logic divisor_zero,
    input wire logic can_overflow,
    input wire logic can_underflow,
    input wire logic can_inexact,
    input wire logic res_sign,
    input wire logic [63:0] res_trunc,
    input wire logic res_guard,
    input wire logic res_sticky,
    input wire logic res_overflow,
    input wire logic res_tiny,
    input wire logic load_system_reg_op,
    input wire logic store_system_reg_op,
    input wire logic [31:0] cpu_wdata,
    input wire logic mov_to_transfer,
    input wire logic mov_from_transfer,
    output logic [31:0] cpu_rdata,
    output logic [31:0] single_view_rdata,
    output logic [31:0] alt_bank_single_view_rdata,
    output logic [63:0] double_pair_view_rdata,
    output logic [63:0] alt_bank_double_view_rdata,
    output logic [127:0] quad_vector_view_rdata,
    output logic [511:0] alt_bank_matrix,
    output logic busy,
    output logic done,
    output logic fpu_exception,
    output frx_disable_t disable_exc,
    output logic [5:0] cause_r,
    output logic [4:0] flag_r
);

    // =================================================================
    // Reset synchroniser.
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // =================================================================
    // Physical storage and view mapping.
    logic [31:0] phys_r [2][16];
    logic [31:0] fr_view [16];
    logic [31:0] xf_view [16];
    logic [31:0] cpu_fpu_transfer_word_r;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_view
            assign fr_view[gi] = phys_r[bank_select_bit][gi];
            assign xf_view[gi] = phys_r[~bank_select_bit][gi];
            assign alt_bank_matrix[(gi*32)+:32] = xf_view[gi];
        end
    endgenerate

    always_comb
    begin
        single_view_rdata = fr_view[src_reg[3:0]];
        alt_bank_single_view_rdata = xf_view[src_reg[3:0]];
        double_pair_view_rdata = {fr_view[{src_reg[3:1], 1'b0}],
            fr_view[{src_reg[3:1], 1'b1}]};
        alt_bank_double_view_rdata = {xf_view[{src_reg[3:1], 1'b0}],
            xf_view[{src_reg[3:1], 1'b1}]};
        quad_vector_view_rdata = {fr_view[{src_reg[3:2], 2'h0}],
            fr_view[{src_reg[3:2], 2'h1}], fr_view[{src_reg[3:2], 2'h2}],
            fr_view[{src_reg[3:2], 2'h3}]};
    end

    // =================================================================
    // Exception source evaluation.
    logic rounded;
    logic exc_e;
    logic exc_v;
    logic exc_z;
    logic exc_o;
    logic exc_u;
    logic exc_i;
    logic [5:0] occur;
    logic trap;
    logic dz_op;
    logic ovf_carry;

    always_comb
    begin
        dz_op = (op_kind == FRX_OP_DIV) || (op_kind == FRX_OP_RSQRT);
        rounded = res_guard | res_sticky;
        exc_e = src_denormal & ~denormal_flush;
        exc_v = src_invalid;
        exc_z = dz_op & divisor_zero;
        // A round-up carry out of the largest finite magnitude overflows as well.
        ovf_carry = (rounding_select == `FRX_RND_NEAREST) & res_guard
            & (res_sticky | res_trunc[0])
            & (is_double ? (res_trunc[62:0] == `FRX_MAX_D) : (res_trunc[30:0] == `FRX_MAX_S));
        exc_o = res_overflow | ovf_carry;
        exc_u = res_tiny & rounded;
        exc_i = exc_o | exc_u | rounded;
        occur = 6'h00;
        occur[`FRX_EXC_E] = exc_e;
        occur[`FRX_EXC_V] = exc_v;
        occur[`FRX_EXC_Z] = exc_z;
        occur[`FRX_EXC_O] = exc_o;
        occur[`FRX_EXC_U] = exc_u;
        occur[`FRX_EXC_I] = exc_i;
        trap = exc_e
            | (enable_bits[`FRX_EXC_V] & ((op_kind == FRX_OP_XFORM) | exc_v))
            | (enable_bits[`FRX_EXC_Z] & exc_z)
            | (enable_bits[`FRX_EXC_O] & can_overflow)
            | (enable_bits[`FRX_EXC_U] & can_underflow)
            | (enable_bits[`FRX_EXC_I] & can_inexact);
    end

    // =================================================================
    // Rounding and default results.
    logic [63:0] rounded_mag;
    logic [63:0] result;
    logic round_up;

    always_comb
    begin
        round_up = 1'b0;
        if (rounding_select == `FRX_RND_NEAREST)
            round_up = res_guard & (res_sticky | res_trunc[0]);
        rounded_mag = res_trunc + {63'h0, round_up};
        if (is_double)
        begin
            result = {res_sign, rounded_mag[62:0]};
            if (exc_v)
                result = `FRX_QNAN_D;
            else if (exc_z)
                result = {res_sign, `FRX_INF_D};
            else if (exc_o && rounding_select == `FRX_RND_ZERO)
                result = {res_sign, `FRX_MAX_D};
            else if (exc_o)
                result = {res_sign, `FRX_INF_D};
            else if (exc_u && denormal_flush)
                result = {res_sign, 63'h0};
        end
        else
        begin
            result = {32'h0, res_sign, rounded_mag[30:0]};
            if (exc_v)
                result = {32'h0, `FRX_QNAN_S};
            else if (exc_z)
                result = {32'h0, res_sign, `FRX_INF_S};
            else if (exc_o && rounding_select == `FRX_RND_ZERO)
                result = {32'h0, res_sign, `FRX_MAX_S};
            else if (exc_o)
                result = {32'h0, res_sign, `FRX_INF_S};
            else if (exc_u && denormal_flush)
                result = {32'h0, res_sign, 31'h0};
        end
    end

    // =================================================================
    // Instruction sequencing.
    frx_state_t state_r;
    logic [63:0] result_r;
    logic trap_r;
    logic [5:0] occur_r;
    logic [3:0] dst_r;
    logic dbl_r;
    logic bank_r;

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= FRX_ST_IDLE;
            result_r <= 64'h0;
            trap_r <= 1'b0;
            occur_r <= 6'h00;
            dst_r <= 4'h0;
            dbl_r <= 1'b0;
            bank_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                FRX_ST_IDLE:
                begin
                    if (issue && !unit_disable_bit && op_kind != FRX_OP_NONE)
                        state_r <= FRX_ST_EXEC;
                end
                FRX_ST_EXEC:
                begin
                    result_r <= (op_kind == FRX_OP_MOVE)
                        ? {32'h0, cpu_fpu_transfer_word_r} : result;
                    trap_r <= (op_kind != FRX_OP_MOVE) & trap;
                    occur_r <= (op_kind == FRX_OP_MOVE) ? 6'h00 : occur;
                    dst_r <= dst_reg;
                    dbl_r <= is_double & (op_kind != FRX_OP_MOVE);
                    bank_r <= bank_select_bit;
                    state_r <= ((op_kind != FRX_OP_MOVE) & trap) ? FRX_ST_TRAP : FRX_ST_WB;
                end
                FRX_ST_WB: state_r <= FRX_ST_IDLE;
                FRX_ST_TRAP: state_r <= FRX_ST_IDLE;
            endcase
        end
    end

    assign busy = (state_r != FRX_ST_IDLE);
    assign done = (state_r == FRX_ST_WB) || (state_r == FRX_ST_TRAP);
    assign fpu_exception = (state_r == FRX_ST_TRAP) && trap_r;

    // Writeback skips the destination entirely when the trap path is taken.
    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            for (int b = 0; b < 2; b++)
                for (int r = 0; r < 16; r++)
                    phys_r[b][r] <= `FRX_FREG_RESET;
        end
        else if (state_r == FRX_ST_WB)
        begin
            if (dbl_r)
            begin
                phys_r[bank_r][{dst_r[3:1], 1'b0}] <= result_r[63:32];
                phys_r[bank_r][{dst_r[3:1], 1'b1}] <= result_r[31:0];
            end
            else
                phys_r[bank_r][dst_r] <= result_r[31:0];
        end
    end

    // =================================================================
    // Cause and sticky flags.
    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            cause_r <= 6'h00;
            flag_r <= 5'h00;
        end
        else
        begin
            if (state_r == FRX_ST_WB || state_r == FRX_ST_TRAP)
                cause_r <= occur_r;
            // Set wins over a simultaneous software clear.
            flag_r <= (flag_r & ~flag_clear[4:0])
                | (done ? occur_r[4:0] : 5'h00);
        end
    end

    // =================================================================
    // Disable exception and transfer word.
    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            disable_exc <= FRX_DIS_NONE;
        else if (issue && unit_disable_bit && state_r == FRX_ST_IDLE)
            disable_exc <= in_delay_slot ? FRX_DIS_SLOT : FRX_DIS_GENERAL;
        else
            disable_exc <= FRX_DIS_NONE;
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            cpu_fpu_transfer_word_r <= `FRX_XFER_RESET;
        else if (load_system_reg_op)
            cpu_fpu_transfer_word_r <= cpu_wdata;
        else if (mov_to_transfer && !unit_disable_bit)
            cpu_fpu_transfer_word_r <= single_view_rdata;
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            cpu_rdata <= 32'h0;
        else if (store_system_reg_op)
            cpu_rdata <= cpu_fpu_transfer_word_r;
    end

    // =================================================================
    // Assertions.
    property p_trap_keeps_dest;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (state_r == FRX_ST_TRAP) |=> $stable(phys_r[bank_r][dst_r]);
    endproperty
    a_trap_keeps_dest: assert property (p_trap_keeps_dest)
        else $error("Destination changed on trap.");

    property p_err_traps;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (state_r == FRX_ST_EXEC && op_kind != FRX_OP_MOVE && exc_e) |=> fpu_exception;
    endproperty
    a_err_traps: assert property (p_err_traps)
        else $error("Denormal input did not trap.");

    property p_disable_variant;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (issue && unit_disable_bit && state_r == FRX_ST_IDLE)
            |=> disable_exc == ($past(in_delay_slot) ? FRX_DIS_SLOT : FRX_DIS_GENERAL);
    endproperty
    a_disable_variant: assert property (p_disable_variant)
        else $error("Wrong disable exception variant.");

    property p_flag_sticky;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (flag_clear == 6'h00) |=> ((flag_r & $past(flag_r)) == $past(flag_r));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("Sticky flag lost.");

    property p_cause_follows;
        @(posedge clk_sys) disable iff (!rst_n_r)
        done |=> cause_r == $past(occur_r);
    endproperty
    a_cause_follows: assert property (p_cause_follows)
        else $error("Cause bits not rewritten.");

    property p_xfer_load;
        @(posedge clk_sys) disable iff (!rst_n_r)
        load_system_reg_op ##1 store_system_reg_op |=> cpu_rdata == $past(cpu_wdata, 2);
    endproperty
    a_xfer_load: assert property (p_xfer_load)
        else $error("Transfer word round trip failed.");

    property p_xform_traps;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (state_r == FRX_ST_EXEC && op_kind == FRX_OP_XFORM && enable_bits[`FRX_EXC_V])
            |=> fpu_exception;
    endproperty
    a_xform_traps: assert property (p_xform_traps)
        else $error("Transform with invalid enable did not trap.");

    property p_exec_two_cycles;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (state_r == FRX_ST_EXEC) |=> done ##1 !busy;
    endproperty
    a_exec_two_cycles: assert property (p_exec_two_cycles)
        else $error("Instruction sequence length wrong.");

endmodule

// *** sim/frx_cpu_model.sv ***
`timescale 1ns/10ps
// =====================================================================
// CPU core model: issues instructions and moves words through the transfer word.
module frx_cpu_model
    import frx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic done,
    input wire logic fpu_exception,
    input wire frx_disable_t disable_exc,
    output logic issue,
    output frx_op_t op_kind,
    output logic in_delay_slot,
    output logic load_system_reg_op,
    output logic store_system_reg_op,
    output logic [31:0] cpu_wdata
);
    initial
    begin
        issue = 1'b0;
        op_kind = FRX_OP_NONE;
        in_delay_slot = 1'b0;
        load_system_reg_op = 1'b0;
        store_system_reg_op = 1'b0;
        cpu_wdata = 32'h00000000;
    end

    // The data lines go inverted after a load so that stale data never looks valid.
    task automatic load(input logic [31:0] d);
        @(posedge clk_sys);
        load_system_reg_op <= 1'b1;
        cpu_wdata <= d;
        @(posedge clk_sys);
        load_system_reg_op <= 1'b0;
        cpu_wdata <= ~d;
    endtask

    // Load and store on consecutive edges: the store returns the word just loaded.
    task automatic load_store(input logic [31:0] d);
        @(posedge clk_sys);
        load_system_reg_op <= 1'b1;
        cpu_wdata <= d;
        @(posedge clk_sys);
        load_system_reg_op <= 1'b0;
        store_system_reg_op <= 1'b1;
        cpu_wdata <= ~d;
        @(posedge clk_sys);
        store_system_reg_op <= 1'b0;
    endtask

    task automatic store();
        @(posedge clk_sys);
        store_system_reg_op <= 1'b1;
        @(posedge clk_sys);
        store_system_reg_op <= 1'b0;
    endtask

    // A disabled issue never brings done, so the wait is bounded; a gap makes the core slow.
    task automatic exec(input frx_op_t op, input logic slot, input int gap,
        output logic trap, output frx_disable_t dis);
        trap = 1'bx;
        dis = FRX_DIS_NONE;
        repeat (gap + 1) @(posedge clk_sys);
        issue <= 1'b1;
        op_kind <= op;
        in_delay_slot <= slot;
        @(posedge clk_sys);
        issue <= 1'b0;
        for (int n = 0; n < 6; n++)
        begin
            #1;
            if (disable_exc !== FRX_DIS_NONE)
                dis = disable_exc;
            if (done === 1'b1)
                trap = fpu_exception;
            if (done === 1'b1 || dis !== FRX_DIS_NONE)
                break;
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
    endtask
endmodule

// *** sim/fpu_regbank_round_except_tb.sv ***
`timescale 1ns/10ps
`define CHECK_EQ(g, e) \
    begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end

module fpu_regbank_round_except_tb;
    import frx_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic issue, in_delay_slot, load_system_reg_op, store_system_reg_op;
    frx_op_t op_kind;
    logic [31:0] cpu_wdata, cpu_rdata, single_view_rdata, alt_bank_single_view_rdata;
    logic [63:0] double_pair_view_rdata, alt_bank_double_view_rdata;
    logic [127:0] quad_vector_view_rdata;
    logic [511:0] alt_bank_matrix;
    logic busy, done, fpu_exception, res_sign, tr;
    frx_disable_t disable_exc, dis;
    logic [5:0] cause_r;
    logic [4:0] flag_r, eflag;
    logic unit_disable_bit = 1'b0, bank_select_bit = 1'b0, denormal_flush = 1'b0;
    logic mov_to_transfer = 1'b0, is_double = 1'b0;
    logic [1:0] rounding_select = 2'h0;
    logic [4:0] enable_bits = 5'h00, src_reg = 5'h00;
    logic [5:0] flag_clear = 6'h00;
    logic [3:0] dst_reg = 4'h0;
    logic [9:0] fx = 10'h000;
    logic [63:0] res_trunc = 64'h0;
    logic [31:0] mem [2][16];
    logic [31:0] last, t;
    int num_errors = 0;
    int checked = 0;

    always #50 clk_sys = ~clk_sys;

    frx_cpu_model cpu_u (.clk_sys(clk_sys), .done(done), .fpu_exception(fpu_exception),
        .disable_exc(disable_exc), .issue(issue), .op_kind(op_kind),
        .in_delay_slot(in_delay_slot), .load_system_reg_op(load_system_reg_op),
        .store_system_reg_op(store_system_reg_op), .cpu_wdata(cpu_wdata));

    frx_regbank dut_u (.clk_sys(clk_sys), .nrst(nrst), .issue(issue), .op_kind(op_kind),
        .in_delay_slot(in_delay_slot), .unit_disable_bit(unit_disable_bit),
        .bank_select_bit(bank_select_bit), .rounding_select(rounding_select),
        .denormal_flush(denormal_flush), .enable_bits(enable_bits), .flag_clear(flag_clear),
        .is_double(is_double), .src_reg(src_reg), .dst_reg(dst_reg), .src_denormal(fx[9]),
        .src_invalid(fx[8]), .divisor_zero(fx[7]), .can_overflow(fx[6]),
        .can_underflow(fx[5]), .can_inexact(fx[4]), .res_sign(res_sign),
        .res_trunc(res_trunc), .res_guard(fx[1]), .res_sticky(fx[0]),
        .res_overflow(fx[3]), .res_tiny(fx[2]), .load_system_reg_op(load_system_reg_op),
        .store_system_reg_op(store_system_reg_op), .cpu_wdata(cpu_wdata),
        .mov_to_transfer(mov_to_transfer), .mov_from_transfer(1'b0), .cpu_rdata(cpu_rdata),
        .single_view_rdata(single_view_rdata),
        .alt_bank_single_view_rdata(alt_bank_single_view_rdata),
        .double_pair_view_rdata(double_pair_view_rdata),
        .alt_bank_double_view_rdata(alt_bank_double_view_rdata),
        .quad_vector_view_rdata(quad_vector_view_rdata), .alt_bank_matrix(alt_bank_matrix),
        .busy(busy), .done(done), .fpu_exception(fpu_exception),
        .disable_exc(disable_exc), .cause_r(cause_r), .flag_r(flag_r));

    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] rnd_exp(logic [31:0] v, logic g, logic s, logic [1:0] rm);
        if (rm == 2'h0 && g && (s || v[0]))
            return v + 32'h00000001;
        return v;
    endfunction

    // Facts f: denormal, invalid, zero divisor, can O/U/I, overflow, tiny, guard, sticky.
    task automatic row(input frx_op_t op, input logic [9:0] f, input logic [31:0] v,
        input logic [4:0] en, input logic [1:0] rm, input logic dn, input logic clr,
        input logic [31:0] er, input logic [5:0] ec, input logic et);
        @(posedge clk_sys);
        flag_clear <= clr ? 6'h3F : 6'h00;
        fx <= f;
        res_sign <= v[31];
        res_trunc <= {33'h0, v[30:0]};
        enable_bits <= en;
        rounding_select <= rm;
        denormal_flush <= dn;
        @(posedge clk_sys);
        flag_clear <= 6'h00;
        cpu_u.exec(op, 1'b0, $urandom_range(1, 0), tr, dis);
        #1;
        if (clr)
            eflag = 5'h00;
        `CHECK_EQ(tr, et)
        `CHECK_EQ(busy, 1'b0)
        `CHECK_EQ(single_view_rdata, et ? last : er)
        if (!et || ec[5])
            `CHECK_EQ(cause_r, ec)
        if (!et)
        begin
            eflag = eflag | ec[4:0];
            last = er;
            `CHECK_EQ(flag_r, eflag)
        end
    endtask

    initial
    begin
        res_sign = 1'b0;
        void'($urandom(32'h1497));
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cpu_u.store();
        #1;
        `CHECK_EQ(cpu_rdata, 32'h00000000)
        `CHECK_EQ(cause_r, 6'h00)
        $display("test reset done");
        for (int b = 0; b < 2; b++)
            for (int i = 0; i < 16; i++)
            begin
                mem[b][i] = $urandom;
                @(posedge clk_sys);
                bank_select_bit <= b[0];
                dst_reg <= i[3:0];
                cpu_u.load(mem[b][i]);
                cpu_u.exec(FRX_OP_MOVE, 1'b0, $urandom_range(2, 0), tr, dis);
            end
        for (int b = 0; b < 2; b++)
            for (int i = 0; i < 16; i++)
            begin
                @(posedge clk_sys);
                bank_select_bit <= b[0];
                src_reg <= {1'b0, i[3:0]};
                #1;
                `CHECK_EQ(single_view_rdata, mem[b][i])
                `CHECK_EQ(alt_bank_single_view_rdata, mem[1-b][i])
                `CHECK_EQ(alt_bank_matrix[32*i +: 32], mem[1-b][i])
                if (i % 2 == 0)
                begin
                    `CHECK_EQ(double_pair_view_rdata, {mem[b][i], mem[b][i+1]})
                    `CHECK_EQ(alt_bank_double_view_rdata, {mem[1-b][i], mem[1-b][i+1]})
                end
                if (i % 4 == 0)
                    `CHECK_EQ(quad_vector_view_rdata,
                        {mem[b][i], mem[b][i+1], mem[b][i+2], mem[b][i+3]})
            end
        $display("test view mapping done");
        @(posedge clk_sys);
        src_reg <= 5'h05;
        mov_to_transfer <= 1'b1;
        @(posedge clk_sys);
        mov_to_transfer <= 1'b0;
        cpu_u.store();
        #1;
        `CHECK_EQ(cpu_rdata, mem[1][5])
        t = $urandom;
        cpu_u.load(t);
        cpu_u.store();
        #1;
        `CHECK_EQ(cpu_rdata, t)
        cpu_u.load_store(~t);
        #1;
        `CHECK_EQ(cpu_rdata, ~t)
        $display("test transfer word done");
        @(posedge clk_sys);
        bank_select_bit <= 1'b0;
        src_reg <= 5'h03;
        dst_reg <= 4'h3;
        eflag = 5'h00;
        last = mem[0][3];
        row(FRX_OP_ARITH, 10'h100, 32'h3F800000, 5'h00, 2'h0, 1'b0, 1'b1,
            32'h7FBFFFFF, 6'h10, 1'b0);
        row(FRX_OP_DIV, 10'h080, 32'h80000000, 5'h00, 2'h0, 1'b0, 1'b1,
            32'hFF800000, 6'h08, 1'b0);
        row(FRX_OP_ARITH, 10'h048, 32'h7F7FFFFF, 5'h00, 2'h0, 1'b0, 1'b1,
            32'h7F800000, 6'h05, 1'b0);
        row(FRX_OP_ARITH, 10'h000, 32'h3F800000, 5'h00, 2'h0, 1'b0, 1'b0,
            32'h3F800000, 6'h00, 1'b0);
        row(FRX_OP_ARITH, 10'h048, 32'hFF7FFFFF, 5'h00, 2'h1, 1'b0, 1'b1,
            32'hFF7FFFFF, 6'h05, 1'b0);
        row(FRX_OP_ARITH, 10'h042, 32'h7F7FFFFF, 5'h00, 2'h0, 1'b0, 1'b1,
            32'h7F800000, 6'h05, 1'b0);
        row(FRX_OP_ARITH, 10'h026, 32'h80000001, 5'h00, 2'h0, 1'b1, 1'b1,
            32'h80000000, 6'h03, 1'b0);
        row(FRX_OP_ARITH, 10'h012, 32'h3F800001, 5'h00, 2'h0, 1'b0, 1'b1,
            32'h3F800002, 6'h01, 1'b0);
        row(FRX_OP_ARITH, 10'h200, 32'h3F800000, 5'h00, 2'h0, 1'b0, 1'b1,
            32'h0, 6'h20, 1'b1);
        row(FRX_OP_XFORM, 10'h000, 32'h3F800000, 5'h10, 2'h0, 1'b0, 1'b1,
            32'h0, 6'h00, 1'b1);
        row(FRX_OP_RSQRT, 10'h080, 32'h3F800000, 5'h08, 2'h0, 1'b0, 1'b1,
            32'h0, 6'h00, 1'b1);
        for (int k = 0; k < 3; k++)
            row(FRX_OP_ARITH, 10'h040 >> k, 32'h3F800000, 5'h04 >> k, 2'h0, 1'b0, 1'b1,
                32'h0, 6'h00, 1'b1);
        $display("test exceptions done");
        for (int k = 0; k < 40; k++)
        begin
            logic [1:0] gs;
            logic [1:0] rm;
            gs = $urandom_range(3, 0);
            rm = $urandom_range(1, 0);
            t = $urandom & 32'h80FFFFFF | 32'h3E000000;
            row(FRX_OP_ARITH, {8'h04, gs}, t, 5'h00, rm, 1'b0, 1'b1,
                rnd_exp(t, gs[1], gs[0], rm), {5'h00, |gs}, 1'b0);
        end
        $display("test rounding done");
        @(posedge clk_sys);
        is_double <= 1'b1;
        row(FRX_OP_ARITH, 10'h100, 32'h3F800000, 5'h00, 2'h0, 1'b0, 1'b1,
            32'hFFFFFFFF, 6'h10, 1'b0);
        `CHECK_EQ(double_pair_view_rdata, 64'h7FF7FFFFFFFFFFFF)
        $display("test double result done");
        @(posedge clk_sys);
        unit_disable_bit <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            cpu_u.exec(FRX_OP_ARITH, s[0], 0, tr, dis);
            `CHECK_EQ(dis, s ? FRX_DIS_SLOT : FRX_DIS_GENERAL)
        end
        $display("test unit disable done");
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
